//--- lcou_consts.vh
`ifndef LCOU_CONSTS_VH
`define LCOU_CONSTS_VH

// ----------------------------------------
// Instruction encodings (12-bit words)
// ----------------------------------------
`define LCOU_OP_NOT_MASK   12'hFE0
`define LCOU_OP_NOT_VAL    12'h260
`define LCOU_OP_ORF_MASK   12'hFE0
`define LCOU_OP_ORF_VAL    12'h120
`define LCOU_OP_ORW_MASK   12'hFE0
`define LCOU_OP_ORW_VAL    12'h100
`define LCOU_OP_ORL_MASK   12'hF00
`define LCOU_OP_ORL_VAL    12'hD00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCOU_ADDR_MSB      4
`define LCOU_ADDR_LSB      0
`define LCOU_LIT_MSB       7
`define LCOU_LIT_LSB       0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCOU_W_RST         8'h00
`define LCOU_Z_RST         1'b0
`define LCOU_ZERO_BYTE     8'h00

`endif

//--- lcou_unit.v
// Operation
// - Complement instruction inverts addressed file register and writes it back, one cycle.
// - Zero flag set when 8-bit result is zero, cleared otherwise, all four.
// - OR-into-register writes register OR accumulator into register; accumulator unchanged.
// - OR-into-accumulator writes accumulator OR register into accumulator; register unchanged.
// - OR-immediate writes accumulator OR low eight literal bits into accumulator.
`timescale 1ns/1ps
`default_nettype none
`include "lcou_consts.vh"

module lcou_unit #(
  parameter IW = 12,
  parameter DW = 8,
  parameter AW = 5
) (
  // ----------------------------------------
  // Clock and reset
  // ----------------------------------------
  input  wire          clk,
  input  wire          nrst,
  // ----------------------------------------
  // Instruction from decoder
  // ----------------------------------------
  input  wire          instr_valid,
  input  wire [IW-1:0] instr,
  // ----------------------------------------
  // File register side
  // ----------------------------------------
  output wire [AW-1:0] file_register_addr,
  input  wire [DW-1:0] file_register_operand,
  output reg           file_register_we,
  output reg  [DW-1:0] file_register_wdata,
  // ----------------------------------------
  // Core state and status
  // ----------------------------------------
  output reg  [DW-1:0] w_reg,
  output reg           z_flag,
  output wire          instr_hit
);

  // ----------------------------------------
  // Local codes
  // ----------------------------------------
  localparam [3:0] OPS_NOT  = 4'h1;
  localparam [3:0] OPS_ORF  = 4'h2;
  localparam [3:0] OPS_ORW  = 4'h4;
  localparam [3:0] OPS_ORL  = 4'h8;
  localparam [1:0] SRC_NONE = 2'h0;
  localparam [1:0] SRC_INV  = 2'h1;
  localparam [1:0] SRC_ORR  = 2'h2;
  localparam [1:0] SRC_ORL  = 2'h3;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [IW-1:0] not_field;
  wire [IW-1:0] orf_field;
  wire [IW-1:0] orw_field;
  wire [IW-1:0] orl_field;
  reg           is_not;
  reg           is_orf;
  reg           is_orw;
  reg           is_orl;
  wire [3:0]    op_sel;

  assign not_field          = instr & `LCOU_OP_NOT_MASK;
  assign orf_field          = instr & `LCOU_OP_ORF_MASK;
  assign orw_field          = instr & `LCOU_OP_ORW_MASK;
  assign orl_field          = instr & `LCOU_OP_ORL_MASK;
  assign op_sel             = {is_orl, is_orw, is_orf, is_not};
  assign file_register_addr = instr[`LCOU_ADDR_MSB:`LCOU_ADDR_LSB];

  always @* begin
    is_not = 1'b0;
    is_orf = 1'b0;
    is_orw = 1'b0;
    is_orl = 1'b0;
    if (instr_valid) begin
      is_not = (not_field == `LCOU_OP_NOT_VAL);
      is_orf = (orf_field == `LCOU_OP_ORF_VAL);
      is_orw = (orw_field == `LCOU_OP_ORW_VAL);
      is_orl = (orl_field == `LCOU_OP_ORL_VAL);
    end
  end

  // ----------------------------------------
  // Hit flag
  // ----------------------------------------
  assign instr_hit = is_not | is_orf | is_orw | is_orl;

  // ----------------------------------------
  // Source select
  // ----------------------------------------
  reg  [1:0]    res_src;

  always @* begin
    res_src = SRC_NONE;
    case (op_sel)
      OPS_NOT: begin
        res_src = SRC_INV;
      end
      OPS_ORF: begin
        res_src = SRC_ORR;
      end
      OPS_ORW: begin
        res_src = SRC_ORR;
      end
      OPS_ORL: begin
        res_src = SRC_ORL;
      end
      default: begin
        res_src = SRC_NONE;
      end
    endcase
  end

  // ----------------------------------------
  // Per-bit logic
  // ----------------------------------------
  wire [DW-1:0] lit_operand;
  wire [DW-1:0] inv_vec;
  wire [DW-1:0] or_reg_vec;
  wire [DW-1:0] or_lit_vec;

  assign lit_operand = instr[`LCOU_LIT_MSB:`LCOU_LIT_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < DW; gi = gi + 1) begin : g_bit
      wire opd_bit;
      wire acc_bit;
      assign opd_bit        = file_register_operand[gi];
      assign acc_bit        = w_reg[gi];
      assign inv_vec[gi]    = ~opd_bit;
      assign or_reg_vec[gi] = opd_bit | acc_bit;
      assign or_lit_vec[gi] = acc_bit | lit_operand[gi];
    end
  endgenerate

  // ----------------------------------------
  // Result mux
  // ----------------------------------------
  reg  [DW-1:0] next_result;

  always @* begin
    next_result = `LCOU_ZERO_BYTE;
    case (res_src)
      SRC_INV: begin
        next_result = inv_vec;
      end
      SRC_ORR: begin
        next_result = or_reg_vec;
      end
      SRC_ORL: begin
        next_result = or_lit_vec;
      end
      default: begin
        next_result = `LCOU_ZERO_BYTE;
      end
    endcase
  end

  // ----------------------------------------
  // Zero detect
  // ----------------------------------------
  wire          res_zero;

  assign res_zero = (next_result == `LCOU_ZERO_BYTE);

  // ----------------------------------------
  // Write-back enables
  // ----------------------------------------
  wire          wb_file;
  wire          wb_acc;

  assign wb_file = is_not | is_orf;
  assign wb_acc  = is_orw | is_orl;

  // ----------------------------------------
  // File register write strobe
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      file_register_we <= 1'b0;
    end else begin
      file_register_we <= wb_file;
    end
  end

  // ----------------------------------------
  // File register write data
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      file_register_wdata <= `LCOU_ZERO_BYTE;
    end else if (wb_file) begin
      file_register_wdata <= next_result;
    end
  end

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      w_reg <= `LCOU_W_RST;
    end else if (wb_acc) begin
      w_reg <= next_result;
    end
  end

  // ----------------------------------------
  // Zero flag
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      z_flag <= `LCOU_Z_RST;
    end else if (instr_hit) begin
      z_flag <= res_zero;
    end
  end

endmodule
`default_nettype wire

//--- lcou_rf.sv
`timescale 1ns/1ps
`default_nettype none
module lcou_rf(input wire logic clk,we,input wire logic [4:0] a,input wire logic [7:0] wd,
  output logic [7:0] rd);
  logic [7:0] m[32];logic [4:0] pa;
  initial for(int j=0;j<32;j++) m[j]=8'(j*37);
  assign rd=m[a];
  // Write lands a cycle late, so use last address
  always @(posedge clk) begin pa<=a;if(we) m[pa]<=wd;end
endmodule
`default_nettype wire

//--- lcou_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lcou_chk(input wire logic clk,nrst,instr_valid,file_register_we,z_flag,
  input wire logic [7:0] file_register_operand,file_register_wdata,w_reg,
  input wire logic [11:0] instr,input wire logic [4:0] file_register_addr);
  default clocking @(posedge clk);endclocking
  default disable iff(!nrst);
  wire [6:0] o=instr_valid?instr[11:5]:7'h00;
  wire [7:0] d=file_register_operand,q=file_register_wdata;
  wire e=file_register_we,h=o==8||o==9||o==19||o[6:3]==13;
  addr_map_a:assert property(file_register_addr==instr[4:0])else $error("adr");
  not_wb_a:assert property(o==19|=>e&&q==~$past(d))else $error("not");
  orf_wb_a:assert property(o==9|=>e&&q==($past(d)|$past(w_reg)))else $error("orf");
  orw_acc_a:assert property(o==8|=>!e&&w_reg==($past(d)|$past(w_reg)))else $error("orw");
  orl_acc_a:assert property(o[6:3]==13|=>w_reg==($past(w_reg)|$past(instr)&12'h0FF))
    else $error("orl");
  zero_flag_a:assert property(h|=>z_flag==((e?q:w_reg)==0))else $error("z");
endmodule
bind lcou_unit lcou_chk lcou_chk_i(.*);
`default_nettype wire

//--- lcou_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcou_unit_tb;
  logic clk=0,nrst=0,iv=0,we,z,h,ez=0;logic [11:0] i=0;logic [4:0] a;
  logic [7:0] d,wd,w,ew=0,m[32];int miscompares=0,n_compared=0,t=0;
  lcou_unit lcou_unit_i(.clk,.nrst,.instr_valid(iv),.instr(i),.file_register_addr(a),.z_flag(z),
    .file_register_operand(d),.file_register_we(we),.file_register_wdata(wd),.w_reg(w),.instr_hit(h));
  lcou_rf lcou_rf_i(.clk,.we,.a,.wd,.rd(d));
  initial forever #25 clk=~clk;
  always @(posedge clk) if(++t>99) begin miscompares++;end_sim;end
  task end_sim;$display("%0d bad of %0d",miscompares,n_compared);
    if(miscompares==0&&n_compared>0) $display("Testbench passed");else $display("Testbench failed");
    $finish;endtask
  task ck(string s,logic [7:0] e,g);n_compared++;
    if(g!==e) begin miscompares++;$display("[FAIL] %s exp %h got %h",s,e,g);end endtask
  task op(logic [11:0] c);logic [7:0] r;logic f,x;f=c[11:5]==19||c[11:5]==9;
    x=f||c[11:5]==8||c[11:8]==13;r=c[11:5]==19?~m[c[4:0]]:ew|(c[11]?c[7:0]:m[c[4:0]]);
    i=c;iv=1;#1 ck("hit",x,h);ck("adr",c[4:0],a);
    @(negedge clk) iv=0;if(x) begin ez=r==0;if(f) m[c[4:0]]=r;else ew=r;end
    ck("we",f,we);if(f) ck("wd",r,wd);
    ck("w",ew,w);ck("z",ez,z);
    @(negedge clk);endtask
  task t_zero;op(12'h100);op(12'hD00);$display("zero done");endtask
  task t_or;op(12'hD5A);op(12'h10B);op(12'h127);op(12'h107);$display("or done");endtask
  task t_not;op(12'hDFF);op(12'h123);op(12'h263);op(12'h263);op(12'h000);$display("not done");endtask
  initial begin for(int j=0;j<32;j++) m[j]=8'(j*37);repeat(6) @(negedge clk);nrst=1;
    t_zero;t_or;t_not;end_sim;end
endmodule
`default_nettype wire
